// ### src/fpmp_port.sv
// programmer-mode command port of the on-chip flash
`timescale 1ns/1ns
`include "fpmp_cfg.svh"
module fpmp_port
  import fpmp_pkg::*;
#(
  parameter int SETUP_CYCLES = `FPMP_SETUP_CYCLES
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic write_n,
  input wire logic flash_write_permit_pin,
  input wire logic [17:0] address_lines,
  input wire logic [7:0] data_bus_lines_in,
  output logic [7:0] data_bus_lines_out,
  output logic data_bus_lines_oe,
  output logic cmd_ready,
  output logic [17:0] array_rd_addr,
  input wire logic [7:0] array_rd_data,
  output logic array_prog_start,
  output logic [17:0] array_prog_addr,
  output logic array_erase_start,
  output logic prog_data_valid,
  input wire logic prog_data_ready,
  output logic [7:0] prog_data,
  input wire logic array_done,
  input wire logic array_fail,
  input wire logic array_count_over
);
  // ************************
  // pin synchronisers
  // ************************
  logic [29:0] sync1, sync2;
  logic we_prev;
  logic cs_n, oe_n, we_n, permit;
  logic [17:0] addr;
  logic [7:0] din;
  logic wr_evt, rd_cyc;
  // two flops on every pin before use
  always_ff @(posedge clock) begin
    if (srst) begin
      sync1 <= 30'h7;
      sync2 <= 30'h7;
      we_prev <= 1'b1;
    end else begin
      sync1 <= {flash_write_permit_pin, address_lines, data_bus_lines_in, write_n, out_en_n, chip_sel_n};
      sync2 <= sync1;
      we_prev <= sync2[2];
    end
  end
  assign cs_n = sync2[0];
  assign oe_n = sync2[1];
  assign we_n = sync2[2];
  assign din = sync2[10:3];
  assign addr = sync2[28:11];
  assign permit = sync2[29];
  // command write ends on the rising write strobe
  assign wr_evt = we_n && !we_prev && !cs_n && oe_n;
  assign rd_cyc = !cs_n && !oe_n && we_n;
  // command byte to operation
  function automatic fpmp_op_t fpmp_decode(input logic [7:0] b);
    case (b)
      `FPMP_CMD_READ: fpmp_decode = FPMP_OP_READ;
      `FPMP_CMD_PROG: fpmp_decode = FPMP_OP_PROG;
      `FPMP_CMD_ERASE: fpmp_decode = FPMP_OP_ERASE;
      `FPMP_CMD_STAT: fpmp_decode = FPMP_OP_STAT;
      default: fpmp_decode = FPMP_OP_BAD;
    endcase
  endfunction
  // ************************
  // sequencer
  // ************************
  fpmp_state_t state, next_state;
  logic [31:0] setup_cnt, next_setup_cnt;
  logic [7:0] byte_cnt, next_byte_cnt;
  logic [17:0] page_addr, next_page_addr;
  logic [7:0] flags, next_flags; // indexed by status bit position
  logic poll_ok, next_poll_ok;
  logic prog_go, next_prog_go;
  logic erase_go, next_erase_go;
  logic [7:0] dout, next_dout;
  logic [7:0] stat_byte;
  logic busy, buf_in_valid, buf_in_ready;
  fpmp_op_t op;
  assign op = fpmp_decode(din);
  assign busy = (state == FPMP_PROG_BUSY) || (state == FPMP_ERASE_BUSY);
  assign buf_in_valid = wr_evt && ((state == FPMP_PROG_ADDR) || (state == FPMP_PROG_DATA));
  // undefined bits 3 and 2 held at zero
  assign stat_byte = {flags[7:4], 2'b00, flags[1:0]};
  always_comb begin
    next_state = state;
    next_setup_cnt = setup_cnt;
    next_byte_cnt = byte_cnt;
    next_page_addr = page_addr;
    next_flags = flags;
    next_poll_ok = poll_ok;
    next_prog_go = 1'b0;
    next_erase_go = 1'b0;
    case (state)
      FPMP_SETUP: begin
        // writes ignored until oscillator and setup time pass
        next_setup_cnt = setup_cnt + 32'h1;
        if (setup_cnt >= 32'(SETUP_CYCLES - 1)) begin
          next_state = FPMP_READ;
        end
      end
      FPMP_PROG_ADDR: begin
        if (wr_evt) begin
          next_page_addr = addr;
          next_byte_cnt = 8'h1;
          if ((addr[7:0] != `FPMP_PAGE_LOW_A) && (addr[7:0] != `FPMP_PAGE_LOW_B)) begin
            next_flags[`FPMP_ST_ADDR] = 1'b1;
          end
          next_state = FPMP_PROG_DATA;
        end
      end
      FPMP_PROG_DATA: begin
        // later address lines are ignored
        if (wr_evt) begin
          next_byte_cnt = byte_cnt + 8'h1;
          if (byte_cnt == `FPMP_PAGE_BYTES - 8'h1) begin
            next_prog_go = 1'b1;
            next_state = FPMP_PROG_BUSY;
          end
        end
      end
      FPMP_PROG_BUSY, FPMP_ERASE_BUSY: begin
        if (array_done) begin
          next_poll_ok = !array_fail && !flags[`FPMP_ST_CMD] && !flags[`FPMP_ST_ADDR];
          if (array_fail) begin
            next_flags[(state == FPMP_PROG_BUSY) ? `FPMP_ST_PROG : `FPMP_ST_ERASE] = 1'b1;
          end
          next_state = FPMP_POLL;
        end
        if (array_count_over) begin
          next_flags[`FPMP_ST_COUNT] = 1'b1;
        end
      end
      FPMP_ERASE_2ND, FPMP_STAT_2ND: begin
        if (wr_evt) begin
          if ((state == FPMP_ERASE_2ND) && (op == FPMP_OP_ERASE) && permit) begin
            next_erase_go = 1'b1;
            next_state = FPMP_ERASE_BUSY;
          end else if ((state == FPMP_STAT_2ND) && (op == FPMP_OP_STAT)) begin
            next_state = FPMP_STATUS;
          end else begin
            next_flags[`FPMP_ST_CMD] = 1'b1;
            next_state = FPMP_READ;
          end
        end
      end
      FPMP_READ, FPMP_POLL, FPMP_STATUS: begin
        // polling flags stand until this write
        if (wr_evt) begin
          next_state = FPMP_READ;
          case (op)
            FPMP_OP_READ: next_state = FPMP_READ;
            FPMP_OP_PROG: begin
              if (permit) begin
                next_flags = 8'h00;
                next_state = FPMP_PROG_ADDR;
              end else begin
                next_flags[`FPMP_ST_CMD] = 1'b1;
              end
            end
            FPMP_OP_ERASE: begin
              next_flags = 8'h00;
              next_state = FPMP_ERASE_2ND;
            end
            FPMP_OP_STAT: next_state = FPMP_STAT_2ND;
            default: next_flags[`FPMP_ST_CMD] = 1'b1;
          endcase
        end
      end
      default: next_state = FPMP_SETUP;
    endcase
    // write during an operation is refused and flagged
    if (busy && wr_evt) begin
      next_flags[`FPMP_ST_CMD] = 1'b1;
    end
    // overrun of the page buffer loses a byte
    if (buf_in_valid && !buf_in_ready) begin
      next_flags[`FPMP_ST_PROG] = 1'b1;
    end
    next_flags[`FPMP_ST_ABN] = |{next_flags[6:4], next_flags[1:0]};
    // read data per mode
    next_dout = 8'h00;
    case (next_state)
      FPMP_READ: next_dout = array_rd_data;
      FPMP_POLL: next_dout = {1'b1, next_poll_ok, 6'h00};
      FPMP_STATUS: next_dout = stat_byte;
      default: next_dout = 8'h00;
    endcase
  end
  // sequencer registers
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= FPMP_SETUP;
      setup_cnt <= 32'h0;
      byte_cnt <= 8'h0;
      page_addr <= 18'h0;
      flags <= 8'h00;
      poll_ok <= 1'b0;
      prog_go <= 1'b0;
      erase_go <= 1'b0;
      dout <= 8'h00;
      array_rd_addr <= 18'h0;
    end else begin
      state <= next_state;
      setup_cnt <= next_setup_cnt;
      byte_cnt <= next_byte_cnt;
      page_addr <= next_page_addr;
      flags <= next_flags;
      poll_ok <= next_poll_ok;
      prog_go <= next_prog_go;
      erase_go <= next_erase_go;
      dout <= next_dout;
      array_rd_addr <= addr;
    end
  end
  // outputs and page buffer
  assign data_bus_lines_out = dout;
  assign data_bus_lines_oe = rd_cyc && (state != FPMP_SETUP);
  assign cmd_ready = (state != FPMP_SETUP);
  assign array_prog_start = prog_go;
  assign array_prog_addr = page_addr;
  assign array_erase_start = erase_go;
  // page bytes queue here, two deep, so an array stall of up to two byte writes loses none
  fpmp_buf fpmp_buf_inst (
    .clock(clock), .srst(srst), .in_valid(buf_in_valid), .in_ready(buf_in_ready), .in_data(din),
    .out_valid(prog_data_valid), .out_ready(prog_data_ready), .out_data(prog_data)
  );
  // ************************
  // checks
  // ************************
  property p_setup_block;
    @(posedge clock) disable iff (srst) (state == FPMP_SETUP) |=> (state inside {FPMP_SETUP, FPMP_READ});
  endproperty
  a_setup_block: assert property (p_setup_block) else $error("left setup into a non-read state");
  property p_prog_start;
    @(posedge clock) disable iff (srst)
      (state == FPMP_PROG_DATA && wr_evt && byte_cnt == 8'h7f) |=> (array_prog_start && state == FPMP_PROG_BUSY);
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("page program not started after 128 bytes");
  property p_addr_err;
    @(posedge clock) disable iff (srst) (state == FPMP_PROG_ADDR && wr_evt && addr[6:0] != 7'h00) |=> stat_byte[0];
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("bad page address not flagged");
  property p_addr_hold;
    @(posedge clock) disable iff (srst) (state == FPMP_PROG_DATA) |=> $stable(page_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("page address changed after second cycle");
  property p_busy_zero;
    @(posedge clock) disable iff (srst) busy |-> (dout == 8'h00);
  endproperty
  a_busy_zero: assert property (p_busy_zero) else $error("busy poll not zero");
  property p_poll_hold;
    @(posedge clock) disable iff (srst) (state == FPMP_POLL && !wr_evt) |=> (state == FPMP_POLL && dout[7]);
  endproperty
  a_poll_hold: assert property (p_poll_hold) else $error("poll flags dropped without write");
  property p_busy_cmd;
    @(posedge clock) disable iff (srst) (busy && wr_evt) |=> (stat_byte[6] && stat_byte[7]);
  endproperty
  a_busy_cmd: assert property (p_busy_cmd) else $error("busy write not flagged");
  property p_reserved;
    @(posedge clock) disable iff (srst) (state == FPMP_STATUS) |-> (dout[3:2] == 2'b00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("undefined status bits not zero");
  property p_erase_go;
    @(posedge clock) disable iff (srst)
      (state == FPMP_ERASE_2ND && wr_evt && din == 8'h20 && permit) |=> ##1 (state == FPMP_ERASE_BUSY && !erase_go);
  endproperty
  a_erase_go: assert property (p_erase_go) else $error("erase pulse not single");
endmodule

// ### src/fpmp_cfg.svh
// constants of the programmer-mode flash command port
`ifndef FPMP_CFG_SVH
`define FPMP_CFG_SVH
// command bytes
`define FPMP_CMD_READ 8'h00
`define FPMP_CMD_PROG 8'h40
`define FPMP_CMD_ERASE 8'h20
`define FPMP_CMD_STAT 8'h71
// page geometry
`define FPMP_PAGE_BYTES 8'h80
`define FPMP_PAGE_LOW_A 8'h00
`define FPMP_PAGE_LOW_B 8'h80
`define FPMP_FILL_BYTE 8'hff
// status byte bit positions
`define FPMP_ST_ABN 7
`define FPMP_ST_CMD 6
`define FPMP_ST_PROG 5
`define FPMP_ST_ERASE 4
`define FPMP_ST_COUNT 1
`define FPMP_ST_ADDR 0
// startup timing
`define FPMP_CLK_KHZ 125000
`define FPMP_T_OSC_MS 10
`define FPMP_T_SETUP_MS 10
`define FPMP_SETUP_CYCLES ((`FPMP_T_OSC_MS + `FPMP_T_SETUP_MS) * `FPMP_CLK_KHZ)
`endif

// ### src/fpmp_pkg.sv
// types of the programmer-mode flash command port
package fpmp_pkg;
  typedef enum logic [2:0] {
    FPMP_OP_READ,
    FPMP_OP_PROG,
    FPMP_OP_ERASE,
    FPMP_OP_STAT,
    FPMP_OP_BAD
  } fpmp_op_t;
  typedef enum logic [3:0] {
    FPMP_SETUP,
    FPMP_READ,
    FPMP_PROG_ADDR,
    FPMP_PROG_DATA,
    FPMP_PROG_BUSY,
    FPMP_ERASE_2ND,
    FPMP_ERASE_BUSY,
    FPMP_POLL,
    FPMP_STAT_2ND,
    FPMP_STATUS
  } fpmp_state_t;
endpackage

// ### src/fpmp_buf.sv
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/1ns
module fpmp_buf (
  input wire logic clock,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);
  logic [7:0] mem [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic [1:0] next_count;
  logic push;
  logic pop;

  // handshake from occupancy
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and occupancy update
  always_comb begin
    next_wr_ptr = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  // registers
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ### bench/fpmp_array_model.sv
// array-side model: takes page bytes, finishes program and erase late
`timescale 1ns/1ns
module fpmp_array_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic prog_start,
  input wire logic erase_start,
  input wire logic [17:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic data_valid,
  output logic data_ready,
  input wire logic [7:0] data,
  output logic done,
  output logic fail,
  output logic count_over,
  input wire logic fail_req,
  output logic [7:0] got_bytes,
  output logic [7:0] last_byte
);
  logic [7:0] cnt;
  logic [7:0] tmr;
  // contents seen as a fixed address pattern
  assign rd_data = rd_addr[7:0] ^ 8'h3c;
  // a failed operation also reports its count limit as hit
  assign count_over = done && fail;
  // byte intake stalls every other cycle; finish 150 cycles after start
  always_ff @(posedge clock) begin
    done <= 1'b0;
    fail <= 1'b0;
    if (srst) begin
      cnt <= 8'h00;
      tmr <= 8'h00;
      data_ready <= 1'b0;
      got_bytes <= 8'h00;
      last_byte <= 8'h00;
    end else begin
      data_ready <= ~data_ready;
      if (data_valid && data_ready) begin
        cnt <= cnt + 8'h01;
        last_byte <= data;
      end
      if (prog_start || erase_start) begin
        tmr <= 8'h96;
      end else if (tmr == 8'h01) begin
        tmr <= 8'h00;
        done <= 1'b1;
        fail <= fail_req;
        got_bytes <= cnt;
        cnt <= 8'h00;
      end else if (tmr != 8'h00) begin
        tmr <= tmr - 8'h01;
      end
    end
  end
endmodule

// ### bench/test_flash_programmer_mode_port.sv
// self-checking bench of the programmer-mode flash command port
`timescale 1ns/1ns
module test_flash_programmer_mode_port;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic chip_sel_n = 1'b1;
  logic out_en_n = 1'b1;
  logic write_n = 1'b1;
  logic flash_write_permit_pin = 1'b1;
  logic [17:0] address_lines = 18'h00000;
  logic [7:0] data_bus_lines_in = 8'h00;
  logic [7:0] data_bus_lines_out, prog_data, array_rd_data, got_bytes, last_byte;
  logic [17:0] array_rd_addr, array_prog_addr;
  logic data_bus_lines_oe, cmd_ready, array_prog_start, array_erase_start;
  logic prog_data_valid, prog_data_ready, array_done, array_fail, array_count_over;
  logic fail_req = 1'b0;
  int err_total = 0;
  int samples_checked = 0;
  localparam int STAT_WAIT = 2500; // 20 us of clocks before a status read
  always #4 clock = ~clock;
  fpmp_port #(.SETUP_CYCLES(20)) fpmp_port_inst (.clock(clock), .srst(srst), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .write_n(write_n), .flash_write_permit_pin(flash_write_permit_pin),
    .address_lines(address_lines), .data_bus_lines_in(data_bus_lines_in),
    .data_bus_lines_out(data_bus_lines_out), .data_bus_lines_oe(data_bus_lines_oe), .cmd_ready(cmd_ready),
    .array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data), .array_prog_start(array_prog_start),
    .array_prog_addr(array_prog_addr), .array_erase_start(array_erase_start),
    .prog_data_valid(prog_data_valid), .prog_data_ready(prog_data_ready), .prog_data(prog_data),
    .array_done(array_done), .array_fail(array_fail), .array_count_over(array_count_over));
  fpmp_array_model fpmp_array_model_inst (.clock(clock), .srst(srst), .prog_start(array_prog_start),
    .erase_start(array_erase_start), .rd_addr(array_rd_addr), .rd_data(array_rd_data),
    .data_valid(prog_data_valid), .data_ready(prog_data_ready), .data(prog_data), .done(array_done),
    .fail(array_fail), .count_over(array_count_over), .fail_req(fail_req), .got_bytes(got_bytes),
    .last_byte(last_byte));
  // compare one byte
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // command write: strobe low 4 cycles, select held past rise
  task wr(input logic [17:0] a, input logic [7:0] d);
    @(posedge clock);
    address_lines <= a;
    data_bus_lines_in <= d;
    chip_sel_n <= 1'b0;
    out_en_n <= 1'b1;
    write_n <= 1'b0;
    repeat (4) @(posedge clock);
    write_n <= 1'b1;
    repeat (4) @(posedge clock);
    chip_sel_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  // read cycle, sampled once data has settled
  task rd(input logic [17:0] a, output logic [7:0] q);
    @(posedge clock);
    address_lines <= a;
    chip_sel_n <= 1'b0;
    out_en_n <= 1'b0;
    repeat (8) @(posedge clock);
    #1 q = data_bus_lines_out;
    chk("drive enable", 8'h01, {7'h00, data_bus_lines_oe});
    @(posedge clock);
    chip_sel_n <= 1'b1;
    out_en_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task rdchk(input logic [17:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    chk("read byte", e, q);
  endtask
  // poll until bit 7 of the read byte rises; reads only, no command write while busy
  // the model's short op time stands in for the polling start wait
  task poll(input logic [7:0] e);
    logic [7:0] q;
    q = 8'h00;
    for (int i = 0; i < 60 && q[7] !== 1'b1; i++) begin
      rd(18'h00000, q);
    end
    chk("poll byte", e, q);
  endtask
  task status(input logic [7:0] e);
    wr(18'h00000, 8'h71);
    wr(18'h00000, 8'h71);
    repeat (STAT_WAIT) @(posedge clock);
    rdchk(18'h00000, e);
  endtask
  // page program: 100 data bytes then all-ones fill
  task do_prog(input logic [17:0] page, input logic [7:0] ep, input logic [7:0] es);
    wr(18'h00000, 8'h40);
    for (int i = 0; i < 128; i++) begin
      wr(page + 18'(i), (i < 100) ? 8'(i) : 8'hff);
    end
    rdchk(18'h00000, 8'h00);
    poll(ep);
    chk("page bytes", 8'h80, got_bytes);
    chk("page addr low", page[7:0], array_prog_addr[7:0]);
    chk("page addr high", page[15:8], array_prog_addr[15:8]);
    chk("last byte", 8'hff, last_byte);
    rdchk(18'h00000, ep);
    status(es);
  endtask
  task t_read;
    wr(18'h00000, 8'h00);
    for (int i = 0; i < 3; i++) begin
      rdchk(18'h00123 + 18'(i * 93), 8'(8'h23 + i * 93) ^ 8'h3c);
    end
  endtask
  task t_prog_good;
    do_prog(18'h00100, 8'hc0, 8'h00);
  endtask
  task t_prog_bad_addr;
    do_prog(18'h00205, 8'h80, 8'h81);
  endtask
  task t_erase(input logic f, input logic [7:0] ep, input logic [7:0] es);
    fail_req <= f;
    wr(18'h00000, 8'h20);
    wr(18'h00000, 8'h20);
    rdchk(18'h00000, 8'h00);
    poll(ep);
    chk("erase bytes", 8'h00, got_bytes);
    status(es);
    fail_req <= 1'b0;
  endtask
  // program command without the permit pin is refused and flagged
  task t_no_permit;
    flash_write_permit_pin <= 1'b0;
    wr(18'h00000, 8'h40);
    status(8'hc0);
    flash_write_permit_pin <= 1'b1;
  endtask
  task t_mismatch;
    wr(18'h00000, 8'h20);
    wr(18'h00000, 8'h71);
    status(8'hc0);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    chk("ready early", 8'h00, {7'h00, cmd_ready});
    repeat (30) @(posedge clock);
    chk("ready", 8'h01, {7'h00, cmd_ready});
    t_read;
    t_prog_good;
    t_prog_bad_addr;
    t_erase(1'b0, 8'hc0, 8'h00);
    t_no_permit;
    t_mismatch;
    t_erase(1'b1, 8'h80, 8'h92);
    give_verdict;
  end
endmodule
